// ### core/scip_dev.sv
// Behaviour
// (R1) Top requester drives 8-bit vector on acknowledge.
// (R2) Priority chain passes until a pending device.
// (R3) Higher priority may preempt when interrupts enabled.
// (R4) Priority out low: in low, not servicing.
// (R5) Separate active-high receive and transmit DMA requests.
// (R6) DMA acknowledge daisy-chains in to out.
// (R7) Interrupt request open-drain, pulled low while pending.
// (R8) Open-drain wait outputs, released after reset.
// (R9) Auto-enable: low clear-to-send enables transmitter.
// (R10) Clear-to-send edges both ways raise interrupt.
// (R11) Carrier detect likewise, gating receiver instead.
// (R12) Async clock multiplier 1, 16, 32 or 64.
// (R13) Receiver samples data on receive clock rise.
// (R14) Software uses one multiplier per channel.
// (R15) Transmitter changes data on transmit clock fall.
// (R16) Second channel shares one receive/transmit clock.
// (R17) Three config bits pick vectoring; non-vectored floats.
// (R18) Master: call, vector, zeros; slave floats first.
// (R19) Acknowledge acts as read strobe.
// (R20) Priority-in and DMA acknowledge act as select.
// (R21) Software loads flag pattern as receive sync.
// (R22) Transmit interrupt four to six clocks later.
// (R23) Receive interrupt seven to eleven clocks later.
// (R24) Vector from software, status may replace bits.
//
// Purpose: Pin-side logic of a dual-channel serial controller.
// Assumes: Link clocks and pins are asynchronous to clk_in.
// Notes: Configuration arrives on plain ports from the user side.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module scip_dev (
   input wire logic clk_in,
   input wire logic rst_b_in,
   scip_if.dev pins,
   input wire logic [7:0] int_cfg_in,
   input wire logic [7:0] vector_in,
   input wire logic [1:0] auto_en_in,
   input wire logic [1:0] mult_in,
   input wire logic [3:0] dma_want_in,
   output logic [1:0] tx_en_out,
   output logic [1:0] rx_en_out,
   output logic [1:0] rx_bit_out,
   output logic [1:0] rx_strobe_out,
   output logic [1:0] cts_level_out,
   output logic [1:0] dcd_level_out,
   output logic [1:0] wait_req_out
);
   typedef enum logic [1:0] {SCIP_A1, SCIP_A2, SCIP_A3} scip_ack_t;
   // Two-flop synchronisers for every asynchronous pin.
   localparam int NS = 12;
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_r;
   logic [NS-1:0] s2_r;
   logic [NS-1:0] s3_r;
   assign raw = {pins.cts_n, pins.dcd_n, pins.receive_clock0,
                 pins.transmit_clock0, pins.shared_clock1, pins.rxd,
                 pins.irq_ack_n, pins.prio_in_n, pins.dma_ack_in_n};
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s1_r <= {NS{1'b1}};
         s2_r <= {NS{1'b1}};
         s3_r <= {NS{1'b1}};
      end
      else
      begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic [1:0] cts_s, dcd_s, rxd_s, cts_p, dcd_p, rxc_s, txc_s, rxc_p, txc_p;
   logic ack_s, ack_p, pri_s, hai_s;
   assign cts_s = s2_r[11:10];
   assign dcd_s = s2_r[9:8];
   assign cts_p = s3_r[11:10];
   assign dcd_p = s3_r[9:8];
   assign rxc_s = {s2_r[5], s2_r[7]}; // R16
   assign txc_s = {s2_r[5], s2_r[6]}; // R16
   assign rxc_p = {s3_r[5], s3_r[7]};
   assign txc_p = {s3_r[5], s3_r[6]};
   assign rxd_s = s2_r[4:3];
   assign ack_s = s2_r[2];
   assign ack_p = s3_r[2];
   assign pri_s = s2_r[1];
   assign hai_s = s2_r[0];
   ////////////////////////////////////////////////////////////////////////
   // Per-channel modem inputs, clock dividers and event pipelines.
   logic [1:0] pend_r;
   logic [1:0] txq_r [0:1];
   logic [5:0] div_r [0:1];
   logic [7:0] txp_r [0:1];
   logic [10:0] rxp_r [0:1];
   logic [1:0] txd_r;
   logic [1:0] rxbit_r;
   logic [1:0] rxstb_r;
   logic [1:0] modem_ev;
   logic [1:0] tx_ev;
   logic [1:0] rx_ev;
   function automatic logic [5:0] div_max(input logic [1:0] m);
      unique case (m) // R12
         scip_pkg::MULT_X1: div_max = 6'h00;
         scip_pkg::MULT_X16: div_max = 6'h0F;
         scip_pkg::MULT_X32: div_max = 6'h1F;
         scip_pkg::MULT_X64: div_max = 6'h3F;
      endcase
   endfunction
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gch
         logic rx_rise, tx_fall, bit_tick;
         assign rx_rise = rxc_s[g] & ~rxc_p[g]; // R13
         assign tx_fall = ~txc_s[g] & txc_p[g]; // R15
         assign bit_tick = rx_rise && (div_r[g] == div_max(mult_in)); // R14
         assign modem_ev[g] = (cts_s[g] ^ cts_p[g]) | (dcd_s[g] ^ dcd_p[g]);
         // Bit-rate divider driven by receive clock edges.
         always_ff @(posedge clk_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
               div_r[g] <= 6'h00;
            else if (rx_rise)
               div_r[g] <= bit_tick ? 6'h00 : div_r[g] + 6'h01;
         end
         // Receive sample and transmit shift on the documented edges.
         always_ff @(posedge clk_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
            begin
               rxbit_r[g] <= 1'b1;
               rxstb_r[g] <= 1'b0;
               txd_r[g] <= 1'b1;
               txp_r[g] <= 8'h00;
               rxp_r[g] <= 11'h000;
            end
            else
            begin
               rxstb_r[g] <= bit_tick && !dcd_s[g];
               if (bit_tick && (!auto_en_in[g] || !dcd_s[g])) // R11
                  rxbit_r[g] <= rxd_s[g]; // R13
               if (tx_fall)
                  txd_r[g] <= (auto_en_in[g] && cts_s[g]) ? 1'b1
                              : rxbit_r[g]; // R9 R15
               txp_r[g] <= {txp_r[g][6:0], tx_fall}; // R22
               rxp_r[g] <= {rxp_r[g][9:0], bit_tick}; // R23
            end
         end
         assign tx_ev[g] = txp_r[g][scip_pkg::TX_INT_DLY-3];
         assign rx_ev[g] = rxp_r[g][scip_pkg::RX_INT_DLY-3];
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   // Pending interrupt and servicing state, acknowledge sequencing.
   logic pending_r, serv_r;
   scip_ack_t ack_st_r;
   logic [7:0] dbus_r;
   logic dbus_oe_n_r, pro_r, hao_r, irq_oe_n_r;
   logic [2:0] mode;
   logic [7:0] vec;
   logic ack_fall, ack_rise, selected;
   assign mode = int_cfg_in[scip_pkg::MODE_LSB +: 3]; // R17
   assign vec = int_cfg_in[scip_pkg::SAV_BIT] ?
                {vector_in[7:3], pend_r[1], 2'h0} : vector_in; // R24
   assign ack_fall = !ack_s && ack_p; // R19
   assign ack_rise = ack_s && !ack_p;
   assign selected = !pri_s && !hai_s; // R20
   // Any tx, rx or modem event makes the device pend.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         pending_r <= 1'b0;
         pend_r <= 2'h0;
      end
      else
      begin
         pend_r <= pend_r | tx_ev | rx_ev | modem_ev; // R10 R11
         if (|(tx_ev | rx_ev | modem_ev))
            pending_r <= 1'b1;
         else if (ack_rise && selected && ack_st_r == SCIP_A1)
         begin
            pending_r <= 1'b0;
            pend_r <= 2'h0;
         end
      end
   end
   // Acknowledge pulse counter and data bus drive.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ack_st_r <= SCIP_A1;
         dbus_r <= 8'h00;
         dbus_oe_n_r <= 1'b1;
         serv_r <= 1'b0;
      end
      else if (ack_fall && selected && pending_r) // R1
      begin
         dbus_oe_n_r <= 1'b1;
         unique case (ack_st_r)
            SCIP_A1:
            begin
               serv_r <= 1'b1;
               // Vectored modes count three pulses; only masters call first.
               if (mode[2]) // R17
               begin
                  dbus_r <= scip_pkg::CALL_OPCODE;
                  dbus_oe_n_r <= mode[1]; // R18
                  ack_st_r <= SCIP_A2;
               end
            end
            SCIP_A2:
            begin
               dbus_r <= vec;
               dbus_oe_n_r <= mode[0]; // R1 R17
               ack_st_r <= SCIP_A3;
            end
            SCIP_A3:
            begin
               dbus_r <= 8'h00; // R18
               dbus_oe_n_r <= mode[0];
               ack_st_r <= SCIP_A1;
            end
         endcase
      end
      else if (ack_rise)
         dbus_oe_n_r <= 1'b1;
      else if (!pending_r && ack_st_r == SCIP_A1)
         serv_r <= 1'b0;
   end
   // Daisy chains and open-drain outputs.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         pro_r <= 1'b1;
         hao_r <= 1'b1;
         irq_oe_n_r <= 1'b1;
      end
      else
      begin
         pro_r <= !(!pri_s && !serv_r && !pending_r); // R2 R4
         hao_r <= hai_s || (|dma_want_in); // R6
         irq_oe_n_r <= !(pending_r && !pri_s); // R3 R7
      end
   end
   assign pins.data_dev = dbus_r;
   assign pins.data_dev_oe_n = dbus_oe_n_r;
   assign pins.prio_out_n = pro_r;
   assign pins.dma_ack_out_n = hao_r;
   assign pins.irq_oe_n = irq_oe_n_r;
   assign pins.txd = txd_r;
   // DMA requests and wait lines follow the user side.
   logic [3:0] drq_r;
   logic [1:0] wait_r;
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         drq_r <= 4'h0;
         wait_r <= 2'h3; // R8
      end
      else
      begin
         drq_r <= dma_want_in; // R5
         wait_r <= ~(dma_want_in[1:0] & ~rxstb_r); // R8
      end
   end
   assign pins.dma_req = drq_r;
   assign pins.wait_oe_n = wait_r;
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         tx_en_out <= 2'h0;
         rx_en_out <= 2'h0;
         cts_level_out <= 2'h3;
         dcd_level_out <= 2'h3;
         wait_req_out <= 2'h0;
         rx_bit_out <= 2'h3;
         rx_strobe_out <= 2'h0;
      end
      else
      begin
         tx_en_out <= ~auto_en_in | ~cts_s; // R9
         rx_en_out <= ~auto_en_in | ~dcd_s; // R11
         cts_level_out <= cts_s;
         dcd_level_out <= dcd_s;
         wait_req_out <= ~wait_r;
         rx_bit_out <= rxbit_r;
         rx_strobe_out <= rxstb_r;
      end
   end
endmodule

// ### core/scip_pkg.sv
// Purpose: Shared constants for the serial controller pin logic.
// Assumes: 125 MHz system clock, active-low asynchronous reset.
// Notes: Register offsets belong to the host-side Avalon slave.
package scip_pkg;
   // Avalon register word offsets (byte address = 4 * index).
   localparam logic [3:0] OFF_INT_CFG = 4'h0;
   localparam logic [3:0] OFF_VECTOR = 4'h1;
   localparam logic [3:0] OFF_CTRL = 4'h2;
   localparam logic [3:0] OFF_STATUS = 4'h3;
   localparam logic [3:0] OFF_ACK = 4'h4;
   localparam logic [3:0] OFF_EVENTS = 4'h5;
   // Interrupt configuration fields: mode bits 5..3, status-affects-vector.
   localparam int MODE_LSB = 3;
   localparam int SAV_BIT = 0;
   localparam logic [2:0] MODE_NONVEC = 3'h0;
   localparam logic [2:0] MODE_M3 = 3'h4;
   localparam logic [2:0] MODE_M3_NOVEC = 3'h5;
   localparam logic [2:0] MODE_S3 = 3'h6;
   localparam logic [2:0] MODE_S3_NOVEC = 3'h7;
   localparam logic [7:0] CALL_OPCODE = 8'hCD;
   localparam logic [7:0] INT_CFG_RST = 8'h00;
   localparam logic [7:0] VECTOR_RST = 8'h00;
   // Control fields.
   localparam int CTL_AUTO0 = 0;
   localparam int CTL_AUTO1 = 1;
   localparam int CTL_MULT_LSB = 2;
   localparam int CTL_IEN = 4;
   localparam int CTL_DRQ_LSB = 5;
   // Clock multiplier codes.
   localparam logic [1:0] MULT_X1 = 2'h0;
   localparam logic [1:0] MULT_X16 = 2'h1;
   localparam logic [1:0] MULT_X32 = 2'h2;
   localparam logic [1:0] MULT_X64 = 2'h3;
   // Interrupt latency windows, in system clocks.
   localparam int TX_INT_DLY = 5;
   localparam int RX_INT_DLY = 9;
   // Serial link clock divider half period, 32 ns of a 64 ns period at 8 ns clock.
   localparam int LINK_CLK_NS = 64;
   localparam int CLK_NS = 8;
   localparam int LINK_HALF = LINK_CLK_NS / CLK_NS / 2;
endpackage

// ### core/scip_if.sv
// Purpose: Pin-level carrier joining the controller and its host.
// Assumes: Open-drain lines resolved here from output enables.
// Notes: Enables are active low: low means the pin is driven low.
`timescale 1ns/1ns
interface scip_if;
   logic [7:0] data_dev;
   logic data_dev_oe_n;
   logic irq_ack_n;
   logic prio_in_n;
   logic prio_out_n;
   logic dma_ack_in_n;
   logic dma_ack_out_n;
   logic [3:0] dma_req;
   logic irq_oe_n;
   logic irq_n;
   logic [1:0] wait_oe_n;
   logic [1:0] wait_n;
   logic [1:0] cts_n;
   logic [1:0] dcd_n;
   logic receive_clock0;
   logic transmit_clock0;
   logic shared_clock1;
   logic [1:0] rxd;
   logic [1:0] txd;
   // Open-drain wires are pulled high unless some end drives low.
   assign irq_n = irq_oe_n;
   assign wait_n = wait_oe_n;
   modport dev (
      output data_dev, data_dev_oe_n, prio_out_n, dma_ack_out_n, dma_req,
      output irq_oe_n, wait_oe_n, txd,
      input irq_ack_n, prio_in_n, dma_ack_in_n, cts_n, dcd_n,
      input receive_clock0, transmit_clock0, shared_clock1, rxd
   );
   modport host (
      input data_dev, data_dev_oe_n, prio_out_n, dma_ack_out_n, dma_req,
      input irq_n, wait_n, txd,
      output irq_ack_n, prio_in_n, dma_ack_in_n, cts_n, dcd_n,
      output receive_clock0, transmit_clock0, shared_clock1, rxd
   );
endinterface

// ### core/scip_host.sv
// Purpose: Host end: Avalon slave that drives the controller's pins.
// Assumes: Software writes acknowledge pulses and chain levels.
// Notes: Link clocks are made here by a divider.
`timescale 1ns/1ns
module scip_host (
   input wire logic clk_in,
   input wire logic rst_b_in,
   scip_if.host pins,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [7:0] int_cfg_out,
   output logic [7:0] vector_out
);
   logic [7:0] cfg_r, vec_r, ctl_r;
   logic ack_r, pri_r, hai_r, wt_r;
   logic [7:0] cap_r;
   logic [2:0] div_r;
   logic lclk_r;
   logic [15:0] s1_r, s2_r;
   // Synchronise the device's pins.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s1_r <= 16'h0000;
         s2_r <= 16'h0000;
      end
      else
      begin
         s1_r <= {pins.data_dev, pins.irq_n, pins.wait_n, pins.dma_req,
                  pins.prio_out_n};
         s2_r <= s1_r;
      end
   end
   // Link clock divider.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         div_r <= 3'h0;
         lclk_r <= 1'b1; // Idle high, as the device's synchronisers expect.
      end
      else if (div_r == 3'(scip_pkg::LINK_HALF - 1))
      begin
         div_r <= 3'h0;
         lclk_r <= !lclk_r;
      end
      else
         div_r <= div_r + 3'h1;
   end
   // Avalon slave: one wait cycle, then the answer.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cfg_r <= scip_pkg::INT_CFG_RST;
         vec_r <= scip_pkg::VECTOR_RST;
         ctl_r <= 8'h00;
         ack_r <= 1'b1;
         pri_r <= 1'b1;
         hai_r <= 1'b1;
         wt_r <= 1'b1;
         cap_r <= 8'h00;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         wt_r <= !(avs_read || avs_write) || !wt_r;
         if (avs_write && !wt_r)
            unique case (avs_address)
               scip_pkg::OFF_INT_CFG: cfg_r <= avs_writedata[7:0];
               scip_pkg::OFF_VECTOR: vec_r <= avs_writedata[7:0];
               scip_pkg::OFF_CTRL: ctl_r <= avs_writedata[7:0];
               scip_pkg::OFF_ACK:
               begin
                  ack_r <= avs_writedata[0];
                  pri_r <= avs_writedata[1];
                  hai_r <= avs_writedata[2];
                  if (avs_writedata[0])
                     cap_r <= pins.data_dev_oe_n ? 8'hFF : s2_r[15:8];
               end
               default: ;
            endcase
         if (avs_read && wt_r)
            unique case (avs_address)
               scip_pkg::OFF_INT_CFG: avs_readdata <= {24'h0, cfg_r};
               scip_pkg::OFF_VECTOR: avs_readdata <= {24'h0, vec_r};
               scip_pkg::OFF_CTRL: avs_readdata <= {24'h0, ctl_r};
               scip_pkg::OFF_STATUS: avs_readdata <= {24'h0, s2_r[7:0]};
               scip_pkg::OFF_ACK: avs_readdata <= {24'h0, cap_r};
               default: avs_readdata <= 32'h00000000;
            endcase
      end
   end
   assign avs_waitrequest = wt_r && (avs_read || avs_write);
   assign int_cfg_out = cfg_r;
   assign vector_out = vec_r;
   assign pins.irq_ack_n = ack_r;
   assign pins.prio_in_n = pri_r;
   assign pins.dma_ack_in_n = hai_r;
   assign pins.cts_n = ~ctl_r[1:0];
   assign pins.dcd_n = ~ctl_r[3:2];
   assign pins.receive_clock0 = lclk_r;
   assign pins.transmit_clock0 = lclk_r;
   assign pins.shared_clock1 = lclk_r;
   assign pins.rxd = ctl_r[5:4];
endmodule

// ### bench/scip_props.sv
// Purpose: Pin-level assertions on the carrier joining device and host.
// Assumes: Inputs are carrier signals, sampled on clk_in.
// Notes: Latency bounds allow for the input synchronisers.
`timescale 1ns/1ns
module scip_props (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic irq_ack_n,
   input wire logic prio_in_n,
   input wire logic prio_out_n,
   input wire logic dma_ack_in_n,
   input wire logic dma_ack_out_n,
   input wire logic [3:0] dma_req,
   input wire logic data_dev_oe_n,
   input wire logic irq_oe_n,
   input wire logic [1:0] cts_n,
   input wire logic [1:0] dcd_n,
   input wire logic shared_clock1
);
   // All checks share the system clock and its reset.
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   ////////////////////////////////////////////////////////////////////////
   // Priority chain and bus drive follow their select inputs.
   a_prio_out_held: assert property (prio_in_n [*4] |-> prio_out_n)
      else $error("priority out low while priority in high");
   a_bus_float_noack: assert property (irq_ack_n [*6] |-> data_dev_oe_n)
      else $error("data bus driven without acknowledge");
   a_bus_float_nosel: assert property (prio_in_n [*6] |-> data_dev_oe_n)
      else $error("data bus driven without select");
   a_bus_drive_cause: assert property ($fell(data_dev_oe_n) |->
      !irq_ack_n && !prio_in_n)
      else $error("data bus drive began outside acknowledge");

   ////////////////////////////////////////////////////////////////////////
   // DMA acknowledge chain.
   a_hao_blocked: assert property (dma_ack_in_n [*4] |-> dma_ack_out_n)
      else $error("dma acknowledge out low without input");
   a_hao_passed: assert property ((!dma_ack_in_n && dma_req == 4'h0) [*4]
      |-> !dma_ack_out_n)
      else $error("dma acknowledge not passed down the chain");

   ////////////////////////////////////////////////////////////////////////
   // Channel 0 modem input transitions raise the shared interrupt line; link clock half period.
   a_irq_on_cts: assert property ($changed(cts_n[0]) |-> ##[1:70] !irq_oe_n)
      else $error("no interrupt after clear-to-send change");
   a_irq_on_dcd: assert property ($changed(dcd_n[0]) |-> ##[1:70] !irq_oe_n)
      else $error("no interrupt after carrier-detect change");
   a_link_clk_half: assert property ($rose(shared_clock1) |->
      shared_clock1 [*4] ##1 !shared_clock1)
      else $error("shared link clock half period wrong");
endmodule

// ### bench/test_serial_ctrl_intr_dma_pins.sv
// Purpose: Self-checking bench for device and host ends joined by the carrier.
// Assumes: Host registers give pin control; device user side is driven here.
// Notes: Floated bus captures read back as all ones.
`timescale 1ns/1ns
module test_serial_ctrl_intr_dma_pins;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest;
   logic [7:0] int_cfg, vector, ctrl_sh;
   logic [1:0] auto_en = 2'h0;
   logic [1:0] mult = 2'h0;
   logic [3:0] dma_want = 4'h0;
   logic [1:0] tx_en, rx_en, rx_bit, rx_strobe;
   int error_cnt = 0;
   int checks = 0;

   ////////////////////////////////////////////////////////////////////////
   // The clock toggles every half period of 4 ns, for a period of 8 ns.
   always #4 clk_in = ~clk_in;

   scip_if scip_if_i ();
   scip_dev scip_dev_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .pins(scip_if_i.dev), .int_cfg_in(int_cfg), .vector_in(vector),
      .auto_en_in(auto_en), .mult_in(mult), .dma_want_in(dma_want),
      .tx_en_out(tx_en), .rx_en_out(rx_en), .rx_bit_out(rx_bit),
      .rx_strobe_out(rx_strobe), .cts_level_out(), .dcd_level_out(),
      .wait_req_out());
   scip_host scip_host_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .pins(scip_if_i.host), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .int_cfg_out(int_cfg),
      .vector_out(vector));
   scip_props scip_props_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .irq_ack_n(scip_if_i.irq_ack_n), .prio_in_n(scip_if_i.prio_in_n),
      .prio_out_n(scip_if_i.prio_out_n),
      .dma_ack_in_n(scip_if_i.dma_ack_in_n),
      .dma_ack_out_n(scip_if_i.dma_ack_out_n),
      .dma_req(scip_if_i.dma_req), .data_dev_oe_n(scip_if_i.data_dev_oe_n),
      .irq_oe_n(scip_if_i.irq_oe_n), .cts_n(scip_if_i.cts_n),
      .dcd_n(scip_if_i.dcd_n), .shared_clock1(scip_if_i.shared_clock1));

   ////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Compares one byte and counts the result.
   task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic [3:0] a, input logic wr,
      input logic [31:0] wd);
      int n;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         error_cnt++;
         stop_test();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_in);
   endtask

   // Waits a number of clocks.
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Waits, bounded, for a receive strobe on the first channel.
   task automatic rx_wait();
      int n;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (rx_strobe[0] !== 1'b1 && n < 100);
      if (rx_strobe[0] !== 1'b1)
      begin
         error_cnt++;
         stop_test();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, released open-drain lines and an unmapped place.
   task automatic t_reset();
      wait_clk(4);
      bus(scip_pkg::OFF_STATUS, 1'b0, 32'h0);
      cmp8(8'hE1, rd[7:0]);
      bus(scip_pkg::OFF_INT_CFG, 1'b0, 32'h0);
      cmp8(scip_pkg::INT_CFG_RST, rd[7:0]);
      bus(scip_pkg::OFF_VECTOR, 1'b0, 32'h0);
      cmp8(scip_pkg::VECTOR_RST, rd[7:0]);
      bus(4'hF, 1'b1, 32'h0000_00FF);
      bus(4'hF, 1'b0, 32'h0);
      cmp8(8'h00, rd[7:0]);
      $display("reset test done");
   endtask

   // DMA requests reach the pins and the acknowledge is chained.
   task automatic t_dma();
      dma_want <= 4'hA;
      wait_clk(6);
      bus(scip_pkg::OFF_STATUS, 1'b0, 32'h0);
      cmp8(8'hB5, rd[7:0]);
      dma_want <= 4'h0;
      bus(scip_pkg::OFF_ACK, 1'b1, 32'h0000_0003);
      wait_clk(6);
      cmp8(8'h00, {7'h0, scip_if_i.dma_ack_out_n});
      bus(scip_pkg::OFF_ACK, 1'b1, 32'h0000_0007);
      wait_clk(6);
      cmp8(8'h01, {7'h0, scip_if_i.dma_ack_out_n});
      $display("dma test done");
   endtask

   // Auto-enable gating and the clear-to-send transition interrupt.
   task automatic t_auto();
      ctrl_sh = 8'h00;
      bus(scip_pkg::OFF_ACK, 1'b1, 32'h0000_0005);
      bus(scip_pkg::OFF_CTRL, 1'b1, 32'h0);
      wait_clk(10);
      cmp8({7'h0, tx_en[0]}, 8'h01);
      auto_en <= 2'h1;
      wait_clk(10);
      cmp8({6'h0, tx_en[0], rx_en[0]}, 8'h00);
      ctrl_sh = 8'h01;
      bus(scip_pkg::OFF_CTRL, 1'b1, {24'h0, ctrl_sh});
      wait_clk(10);
      cmp8({7'h0, tx_en[0]}, 8'h01);
      wait_clk(70);
      bus(scip_pkg::OFF_STATUS, 1'b0, 32'h0);
      cmp8({7'h0, rd[7]}, 8'h00);
      ctrl_sh = 8'h05;
      bus(scip_pkg::OFF_CTRL, 1'b1, {24'h0, ctrl_sh});
      wait_clk(10);
      cmp8({7'h0, rx_en[0]}, 8'h01);
      auto_en <= 2'h0;
      $display("auto enable test done");
   endtask

   // Receive data is sampled on the receive clock.
   task automatic t_rx();
      ctrl_sh = ctrl_sh | 8'h10;
      bus(scip_pkg::OFF_CTRL, 1'b1, {24'h0, ctrl_sh});
      rx_wait();
      rx_wait();
      cmp8({7'h0, rx_bit[0]}, 8'h01);
      ctrl_sh = ctrl_sh & 8'hEF;
      bus(scip_pkg::OFF_CTRL, 1'b1, {24'h0, ctrl_sh});
      rx_wait();
      rx_wait();
      cmp8({7'h0, rx_bit[0]}, 8'h00);
      $display("receive test done");
   endtask

   // Raises an interrupt, then three acknowledge pulses, each captured.
   task automatic t_vec(input logic [2:0] mode, input logic sav,
      input logic [7:0] vec, input logic [23:0] e);
      bus(scip_pkg::OFF_INT_CFG, 1'b1, {24'h0, 2'h0, mode, 2'h0, sav});
      bus(scip_pkg::OFF_VECTOR, 1'b1, {24'h0, vec});
      bus(scip_pkg::OFF_ACK, 1'b1, 32'h0000_0005);
      ctrl_sh = ctrl_sh ^ 8'h01;
      bus(scip_pkg::OFF_CTRL, 1'b1, {24'h0, ctrl_sh});
      wait_clk(70);
      for (int i = 0; i < 3; i++)
      begin
         bus(scip_pkg::OFF_ACK, 1'b1, 32'h0);
         wait_clk(8);
         bus(scip_pkg::OFF_ACK, 1'b1, 32'h0000_0007);
         wait_clk(4);
         bus(scip_pkg::OFF_ACK, 1'b0, 32'h0);
         cmp8(e[23 - 8 * i -: 8], rd[7:0]);
      end
      $display("vector test done mode %h", mode);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, then every scenario in turn.
   initial
   begin
      wait_clk(20);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      t_reset();
      t_dma();
      t_auto();
      t_rx();
      t_vec(scip_pkg::MODE_M3, 1'b0, 8'h5A, 24'hCD5A00);
      t_vec(scip_pkg::MODE_M3_NOVEC, 1'b0, 8'h33, 24'hCDFFFF);
      t_vec(scip_pkg::MODE_S3, 1'b1, 8'hA7, 24'hFFA400);
      t_vec(scip_pkg::MODE_NONVEC, 1'b0, 8'h5A, 24'hFFFFFF);
      stop_test();
   end
endmodule
